// file: core/rom_host.sv
// core-side driver: Avalon-MM command registers to link accesses
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module rom_host
	import rom_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// sub-clock stable pin
	input  wire logic        sub_stable,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// link to the controller
	rom_link.core            link
);

	// sequencer states, gray along the usual path
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_LOAD  = 3'b001,
		H_WR1   = 3'b011,
		H_WR2   = 3'b010,
		H_POLL  = 3'b110,
		H_PWAIT = 3'b111,
		H_DRD   = 3'b101,
		H_DWAIT = 3'b100
	} h_state_t;

	// whole driver state
	typedef struct packed {
		h_state_t    state;     // sequencer
		logic [2:0]  op;        // command in progress
		logic        mode;      // page mode requested
		logic        cts;       // long cycle times requested
		logic [10:0] arg;       // address or data argument
		logic [7:0]  result;    // last byte read
		logic        done_flag; // sticky completion
		logic        refused;   // sticky refusal
		logic        ws;        // waitrequest
		logic [31:0] rdata;     // bus read answer
		logic [7:0]  ptr_lo;    // pointer low byte
		logic [7:0]  ptr_hi;    // pointer high byte
		logic [8:0]  lk_addr;   // link address
		logic        lk_ind;    // link indirect flag
		logic        lk_wr;     // link write strobe
		logic        lk_rd;     // link read strobe
		logic [7:0]  lk_wdata;  // link write byte
		logic [8:0]  w2_addr;   // second write address
		logic        w2_ind;    // second write indirect
		logic [7:0]  w2_data;   // second write byte
		logic        two;       // second write pending
		logic [1:0]  stab_sync; // stable-pin synchroniser
	} host_state_t;

	host_state_t st_reg;   // registered state
	host_state_t st_next;  // next state
	logic [7:0]  base;     // control byte without permit/start
	logic [7:0]  mask;     // start bit to poll for
	logic [8:0]  ptr_loc;  // location the pointer names
	logic        timed_op; // command needs polling

	// next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.lk_wr = 1'b0;
		st_next.lk_rd = 1'b0;
		st_next.stab_sync = {st_reg.stab_sync[0], sub_stable};
		ptr_loc = {st_reg.ptr_hi[0], st_reg.ptr_lo};
		base = CTRL_RESET;
		base[CTS_BIT] = st_reg.cts;
		base[MODE_BIT] = st_reg.mode;
		mask = CTRL_RESET;
		case (st_reg.op)
			OP_READ: mask[READ_START_BIT] = 1'b1;
			OP_PROG: mask[PROG_START_BIT] = 1'b1;
			OP_WIPE: mask[WIPE_START_BIT] = 1'b1;
			default: mask = CTRL_RESET;
		endcase
		timed_op = mask != CTRL_RESET;

		// bus slave: answer prepared, then taken with waitrequest low
		if ((avs_read || avs_write) && st_reg.ws) begin
			st_next.ws = 1'b0;
			case (avs_address)
				CMD_OFS: st_next.rdata = {24'h0, 2'b00, st_reg.cts,
					st_reg.mode, 1'b0, st_reg.op};
				ARG_OFS: st_next.rdata = {21'h0, st_reg.arg};
				STATUS_OFS: st_next.rdata = {16'h0, st_reg.result, 5'h00,
					st_reg.refused, st_reg.done_flag,
					st_reg.state != H_IDLE};
				default: st_next.rdata = 32'h0;
			endcase
		end else begin
			st_next.ws = 1'b1;
			if (avs_write && avs_address == ARG_OFS) begin
				st_next.arg = avs_writedata[10:0];
			end
			// R16 - commands while busy are ignored
			if (avs_write && avs_address == CMD_OFS
				&& st_reg.state == H_IDLE) begin
				st_next.op = avs_writedata[2:0];
				st_next.mode = avs_writedata[CMD_MODE_BIT];
				st_next.cts = avs_writedata[CMD_CTS_BIT];
				st_next.done_flag = 1'b0;
				st_next.refused = 1'b0;
				// R15 - timed cycles need a stable sub-clock
				if ((avs_writedata[2:0] == OP_PROG
					|| avs_writedata[2:0] == OP_WIPE)
					&& !st_reg.stab_sync[1]) begin
					st_next.refused = 1'b1;
				end else if (avs_writedata[2:0] >= OP_SET_ADDR
					&& avs_writedata[2:0] <= OP_WIPE) begin
					// R4 - pointer names the control location
					st_next.ptr_lo = CTRL_OFS;
					st_next.ptr_hi = CTRL_SECTOR;
					st_next.state = H_LOAD;
				end
			end
		end

		// sequencer
		case (st_reg.state)
			// idle: keep the state that a command write chose above
			H_IDLE: st_next.two = 1'b0;
			H_LOAD: begin
				// R3 - control reached through pointer
				st_next.lk_wr = 1'b1;
				st_next.lk_ind = 1'b1;
				st_next.lk_addr = ptr_loc;
				st_next.w2_ind = 1'b1;
				st_next.w2_addr = ptr_loc;
				st_next.two = 1'b1;
				st_next.state = H_WR1;
				case (st_reg.op)
					OP_SET_ADDR: begin
						st_next.lk_ind = 1'b0;
						st_next.lk_addr = ADDR_LOW_LOC;
						st_next.lk_wdata = st_reg.arg[7:0];
						st_next.w2_ind = 1'b0;
						st_next.w2_addr = ADDR_HIGH_LOC;
						st_next.w2_data = {5'h00, st_reg.arg[10:8]};
					end
					// mode bit first, so page loads reach the buffer
					OP_LOAD_DATA: begin
						st_next.lk_wdata = base;
						st_next.w2_ind = 1'b0;
						st_next.w2_addr = DATA_LOC;
						st_next.w2_data = st_reg.arg[7:0];
					end
					// R12 - read permit before read start
					OP_READ: begin
						st_next.lk_wdata = base | 8'h02;
						st_next.w2_data = base | 8'h03;
					end
					// R10 - program permit, then start
					OP_PROG: begin
						st_next.lk_wdata = base | 8'h08;
						st_next.w2_data = base | 8'h0C;
					end
					// R7 - wipe permit, then start
					default: begin
						st_next.lk_wdata = base | 8'h40;
						st_next.w2_data = base | 8'h60;
					end
				endcase
			end
			H_WR1, H_WR2: begin
				// R20 - second write in the very next cycle
				if (st_reg.state == H_WR1 && st_reg.two) begin
					// R14 - each write raises one new bit
					st_next.lk_wr = 1'b1;
					st_next.lk_ind = st_reg.w2_ind;
					st_next.lk_addr = st_reg.w2_addr;
					st_next.lk_wdata = st_reg.w2_data;
					st_next.state = H_WR2;
				end else if (timed_op) begin
					st_next.lk_rd = 1'b1;
					st_next.lk_ind = 1'b1;
					st_next.lk_addr = ptr_loc;
					st_next.state = H_POLL;
				end else begin
					st_next.state = H_IDLE;
				end
			end
			H_POLL: st_next.state = H_PWAIT;
			H_PWAIT: begin
				// R16 - wait for the start bit to fall
				if ((link.rdata & mask) != CTRL_RESET) begin
					st_next.lk_rd = 1'b1;
					st_next.state = H_POLL;
				end else if (st_reg.op == OP_READ) begin
					st_next.lk_rd = 1'b1;
					st_next.lk_ind = 1'b0;
					st_next.lk_addr = DATA_LOC;
					st_next.state = H_DRD;
				end else begin
					st_next.state = H_IDLE;
				end
			end
			H_DRD: st_next.state = H_DWAIT;
			H_DWAIT: begin
				st_next.result = link.rdata;
				st_next.state = H_IDLE;
			end
			default: st_next.state = H_IDLE;
		endcase

		// completion from the controller wins over a clear
		if (link.done) begin
			st_next.done_flag = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.ws <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = st_reg.ws;
	assign link.addr = st_reg.lk_addr;
	assign link.indirect = st_reg.lk_ind;
	assign link.wr = st_reg.lk_wr;
	assign link.rd = st_reg.lk_rd;
	assign link.wdata = st_reg.lk_wdata;

endmodule

// file: core/rom_pkg.sv
// shared constants for the data-memory controller and its core-side driver
package rom_pkg;
	// array geometry
	localparam int         MEM_BYTES  = 2048;
	localparam int         ADDR_W     = 11;
	localparam int         PAGE_BYTES = 16;
	localparam logic [3:0] PAGE_LAST  = 4'hF;
	localparam logic [3:0] NIB_ONE    = 4'h1;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;

	// link locations: bit 8 is the sector, bits 7..0 the offset
	localparam logic [8:0] ADDR_LOW_LOC  = 9'h020;
	localparam logic [8:0] ADDR_HIGH_LOC = 9'h021;
	localparam logic [8:0] DATA_LOC      = 9'h022;
	localparam logic [7:0] CTRL_OFS      = 8'h40;
	localparam logic [7:0] CTRL_SECTOR   = 8'h01;
	localparam logic [8:0] CTRL_LOC      = 9'h140;

	// control register layout
	localparam int         CTS_BIT         = 7;
	localparam int         WIPE_PERMIT_BIT = 6;
	localparam int         WIPE_START_BIT  = 5;
	localparam int         MODE_BIT        = 4;
	localparam int         PROG_PERMIT_BIT = 3;
	localparam int         PROG_START_BIT  = 2;
	localparam int         READ_PERMIT_BIT = 1;
	localparam int         READ_START_BIT  = 0;
	localparam logic [7:0] CTRL_RESET      = 8'h00;

	// cycle times, in microseconds, counted on the sub-clock
	localparam int SUB_CLK_HZ    = 32000;
	localparam int WIPE_US_SHORT = 3200;
	localparam int PROG_US_SHORT = 2200;
	localparam int WIPE_US_LONG  = 3700;
	localparam int PROG_US_LONG  = 3000;
	localparam int TIMER_W       = 8;
	localparam logic [TIMER_W-1:0] WIPE_TICKS_SHORT =
		TIMER_W'((WIPE_US_SHORT * SUB_CLK_HZ + 999999) / 1000000);
	localparam logic [TIMER_W-1:0] PROG_TICKS_SHORT =
		TIMER_W'((PROG_US_SHORT * SUB_CLK_HZ + 999999) / 1000000);
	localparam logic [TIMER_W-1:0] WIPE_TICKS_LONG =
		TIMER_W'((WIPE_US_LONG * SUB_CLK_HZ + 999999) / 1000000);
	localparam logic [TIMER_W-1:0] PROG_TICKS_LONG =
		TIMER_W'((PROG_US_LONG * SUB_CLK_HZ + 999999) / 1000000);
	localparam logic [TIMER_W-1:0] TIMER_ONE = 8'h01;

	// driver register map (byte addresses)
	localparam logic [3:0] CMD_OFS    = 4'h0;
	localparam logic [3:0] ARG_OFS    = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam int         CMD_MODE_BIT = 4;
	localparam int         CMD_CTS_BIT  = 5;

	// driver command codes
	localparam logic [2:0] OP_SET_ADDR  = 3'h1;
	localparam logic [2:0] OP_LOAD_DATA = 3'h2;
	localparam logic [2:0] OP_READ      = 3'h3;
	localparam logic [2:0] OP_PROG      = 3'h4;
	localparam logic [2:0] OP_WIPE      = 3'h5;
endpackage

// file: core/rom_link.sv
// special-register link between the core-side driver and the controller
`timescale 1ns/1ps
interface rom_link;
	logic [8:0] addr;     // sector and offset, or pointer value
	logic       indirect; // access goes through the indirect port
	logic       wr;       // write strobe, one cycle
	logic       rd;       // read strobe, one cycle
	logic [7:0] wdata;    // write byte
	logic [7:0] rdata;    // read byte, valid the cycle after rd
	logic       done;     // pulse when a timed cycle ends

	// core side drives the accesses
	modport core (
		output addr,
		output indirect,
		output wr,
		output rd,
		output wdata,
		input  rdata,
		input  done
	);

	// controller side answers them
	modport dev (
		input  addr,
		input  indirect,
		input  wr,
		input  rd,
		input  wdata,
		output rdata,
		output done
	);
endinterface

// file: core/rom_device.sv
// non-volatile data memory controller with its 2048-byte array
// How it works
// R1 - 2048 byte array reached only via registers
// R2 - address is low byte plus three high bits
// R3 - address/data direct, control only indirect
// R4 - software points pointer pair at control
// R5 - short timing: wipe 3.2 ms, program 2.2 ms
// R6 - long timing: wipe 3.7 ms, program 3.0 ms
// R7 - wipe needs permit; cleared after wipe
// R8 - wipe start honoured only with permit set
// R9 - mode picks byte or 16-byte page
// R10 - program needs permit; cleared after program
// R11 - program start honoured only with permit
// R12 - reads need read permit set
// R13 - read start honoured only with permit
// R14 - one permit/start bit per write
// R15 - software checks sub-clock stable first
// R16 - no register changes during timed cycle
// R17 - read byte held until next operation
// R18 - page mode bumps low nibble, stops 0FH
// R19 - wiped page bytes read zero
// R20 - permit then start in consecutive cycles
// R21 - cycle time counted in sub-clock periods
// R22 - completion pulse when timed cycle ends
`timescale 1ns/1ps
module rom_device
	import rom_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// slow sub-clock pin
	input  wire logic sub_clk,
	// controller status
	output logic      busy,
	// core link
	rom_link.dev      link
);

	// whole controller state, array included
	typedef struct packed {
		logic [MEM_BYTES-1:0][7:0]  mem;      // the array itself
		logic [PAGE_BYTES-1:0][7:0] pbuf;     // page buffer bytes
		logic [PAGE_BYTES-1:0]      tag;      // page entries tagged
		logic [7:0]                 alo;      // address low byte
		logic [2:0]                 ahi;      // address high bits
		logic [7:0]                 data;     // data register
		logic [7:0]                 ctrl;     // control register
		logic                       wipe_arm; // wipe permit just written
		logic                       prog_arm; // program permit just written
		logic [TIMER_W-1:0]         timer;    // sub-clock periods left
		logic [2:0]                 sub_sync; // sub-clock synchroniser
		logic [7:0]                 rdata;    // link read answer
		logic                       done;     // completion pulse
		logic                       busy;     // any start bit set
	} dev_state_t;

	dev_state_t         st_reg;   // registered state
	dev_state_t         st_next;  // next state
	logic [ADDR_W-1:0]  addr;     // current array address
	logic               tick;     // one sub-clock rising edge
	logic [7:0]         v;        // byte written to any register
	logic               sel_low;  // direct access to address low
	logic               sel_high; // direct access to address high
	logic               sel_data; // direct access to data
	logic               sel_ctrl; // indirect access to control
	logic               timed;    // wipe or program running

	// step the page nibble, holding at the last entry
	function automatic logic [3:0] bump(input logic [3:0] nib);
		logic [3:0] r;
		r = nib;
		if (nib != PAGE_LAST) begin
			r = nib + NIB_ONE;
		end
		return r;
	endfunction

	// next-state logic
	always_comb begin
		st_next = st_reg;
		// R2 - eleven bit address
		addr = {st_reg.ahi, st_reg.alo};
		v = link.wdata;
		sel_low = !link.indirect && link.addr == ADDR_LOW_LOC;
		sel_high = !link.indirect && link.addr == ADDR_HIGH_LOC;
		sel_data = !link.indirect && link.addr == DATA_LOC;
		// R3 - control only indirect
		sel_ctrl = link.indirect && link.addr == CTRL_LOC;
		timed = st_reg.ctrl[WIPE_START_BIT] || st_reg.ctrl[PROG_START_BIT];
		st_next.done = 1'b0;
		st_next.wipe_arm = 1'b0;
		st_next.prog_arm = 1'b0;
		// sub-clock crosses two flops before the edge detect
		st_next.sub_sync = {st_reg.sub_sync[1:0], sub_clk};
		tick = st_reg.sub_sync[1] && !st_reg.sub_sync[2];

		// read answers land one cycle after the strobe
		if (link.rd) begin
			if (sel_low) begin
				st_next.rdata = st_reg.alo;
			end else if (sel_high) begin
				// R2 - upper bits read zero
				st_next.rdata = {5'h00, st_reg.ahi};
			end else if (sel_data) begin
				st_next.rdata = st_reg.data;
			end else if (sel_ctrl) begin
				st_next.rdata = st_reg.ctrl;
			end else begin
				// unmapped or direct sector 1 reads as zero
				st_next.rdata = BYTE_ZERO;
			end
		end

		// register writes from the core
		if (link.wr) begin
			if (sel_low) begin
				st_next.alo = v;
			end else if (sel_high) begin
				st_next.ahi = v[2:0];
			end else if (sel_data) begin
				st_next.data = v;
				// R9 - page mode fills the buffer
				if (st_reg.ctrl[MODE_BIT]) begin
					st_next.pbuf[st_reg.alo[3:0]] = v;
					st_next.tag[st_reg.alo[3:0]] = 1'b1;
					// R18 - nibble stops at last entry
					st_next.alo[3:0] = bump(st_reg.alo[3:0]);
				end
			end else if (sel_ctrl) begin
				st_next.ctrl[CTS_BIT] = v[CTS_BIT];
				st_next.ctrl[MODE_BIT] = v[MODE_BIT];
				// R12 - read permit gates reads
				st_next.ctrl[READ_PERMIT_BIT] = v[READ_PERMIT_BIT];
				// R7 - wipe permit held as written
				st_next.ctrl[WIPE_PERMIT_BIT] = v[WIPE_PERMIT_BIT];
				// R10 - program permit held as written
				st_next.ctrl[PROG_PERMIT_BIT] = v[PROG_PERMIT_BIT];
				// R20 - remember a permit written this cycle
				st_next.wipe_arm = v[WIPE_PERMIT_BIT] && !v[WIPE_START_BIT];
				st_next.prog_arm = v[PROG_PERMIT_BIT] && !v[PROG_START_BIT];
				// dropping wipe permit empties the page buffer
				if (st_reg.ctrl[WIPE_PERMIT_BIT] && !v[WIPE_PERMIT_BIT]) begin
					st_next.tag = '0;
					st_next.pbuf = '0;
				end
				// start bits only rise; hardware alone clears them
				if (!timed && !st_reg.ctrl[READ_START_BIT]) begin
					// R13 - read start needs permit
					if (v[READ_START_BIT] && st_reg.ctrl[READ_PERMIT_BIT]) begin
						st_next.ctrl[READ_START_BIT] = 1'b1;
					end
					// R11 - program start needs permit
					if (v[PROG_START_BIT] && st_reg.ctrl[PROG_PERMIT_BIT]
						&& st_reg.prog_arm) begin
						st_next.ctrl[PROG_START_BIT] = 1'b1;
						// R6 - long or short program time
						st_next.timer = v[CTS_BIT] ? PROG_TICKS_LONG
							: PROG_TICKS_SHORT;
					end else if (v[WIPE_START_BIT]
						&& st_reg.ctrl[WIPE_PERMIT_BIT]
						&& st_reg.wipe_arm) begin
						// R8 - wipe start needs permit
						st_next.ctrl[WIPE_START_BIT] = 1'b1;
						// R5 - long or short wipe time
						st_next.timer = v[CTS_BIT] ? WIPE_TICKS_LONG
							: WIPE_TICKS_SHORT;
					end
				end
			end
		end

		// R17 - read completes next cycle and holds
		if (st_reg.ctrl[READ_START_BIT]) begin
			// R1 - array only seen through data
			st_next.data = st_reg.mem[addr];
			st_next.ctrl[READ_START_BIT] = 1'b0;
			if (st_reg.ctrl[MODE_BIT]) begin
				// R18 - page read advances nibble
				st_next.alo[3:0] = bump(st_reg.alo[3:0]);
			end
		end

		// R21 - count sub-clock periods down
		if (timed && tick) begin
			if (st_reg.timer > TIMER_ONE) begin
				st_next.timer = st_reg.timer - TIMER_ONE;
			end else begin
				st_next.timer = '0;
				// R22 - one completion pulse
				st_next.done = 1'b1;
				if (st_reg.ctrl[PROG_START_BIT]) begin
					if (!st_reg.ctrl[MODE_BIT]) begin
						st_next.mem[addr] = st_reg.data;
					end else begin
						// tagged page entries take buffered bytes
						for (int i = 0; i < PAGE_BYTES; i++) begin
							if (st_reg.tag[i]) begin
								st_next.mem[{addr[10:4], 4'(i)}] = st_reg.pbuf[i];
							end
						end
					end
					// R11 - start bit falls at the end
					st_next.ctrl[PROG_START_BIT] = 1'b0;
					// R10 - permit dropped after program
					st_next.ctrl[PROG_PERMIT_BIT] = 1'b0;
				end else begin
					// R19 - tagged page bytes go to zero
					for (int i = 0; i < PAGE_BYTES; i++) begin
						if (st_reg.tag[i]) begin
							st_next.mem[{addr[10:4], 4'(i)}] = BYTE_ZERO;
						end
					end
					st_next.ctrl[WIPE_START_BIT] = 1'b0;
					// R7 - permit dropped after wipe
					st_next.ctrl[WIPE_PERMIT_BIT] = 1'b0;
					st_next.pbuf = '0;
				end
				st_next.tag = '0;
			end
		end

		st_next.busy = st_next.ctrl[WIPE_START_BIT]
			|| st_next.ctrl[PROG_START_BIT]
			|| st_next.ctrl[READ_START_BIT];
	end

	// state register; everything clears on reset, the array too
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops
	assign busy = st_reg.busy;
	assign link.rdata = st_reg.rdata;
	assign link.done = st_reg.done;

endmodule

// file: bench/rom_asserts.sv
// link checker for the data-memory controller and its driver
`timescale 1ns/1ps
module rom_asserts
	import rom_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// link signals
	input wire logic [8:0] addr,
	input wire logic       indirect,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       done
);
	// one domain, so clock and reset are shared
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// permit alone, then start, in consecutive control writes
	sequence s_prog_arm;
		wr && indirect && wdata[PROG_PERMIT_BIT] && !wdata[PROG_START_BIT]
		##1 wr && indirect && wdata[PROG_START_BIT];
	endsequence
	sequence s_wipe_arm;
		wr && indirect && wdata[WIPE_PERMIT_BIT] && !wdata[WIPE_START_BIT]
		##1 wr && indirect && wdata[WIPE_START_BIT];
	endsequence
	// never at once; the bound covers the long wipe on a fast sub-clock
	sequence s_timed_end;
		!done [*8] ##[1:700] done;
	endsequence

	a_prog_timed:
		assert property (s_prog_arm |=> s_timed_end)
		else $error("program cycle did not end in time");
	a_wipe_timed:
		assert property (s_wipe_arm |=> s_timed_end)
		else $error("wipe cycle did not end in time");
	a_done_pulse:
		assert property (done |=> !done)
		else $error("completion pulse longer than one cycle");
	a_strobe_excl:
		assert property (wr |-> !rd)
		else $error("read and write strobes together");
	a_rd_pulse:
		assert property (rd |=> !rd)
		else $error("read strobe longer than one cycle");
	a_rdata_hold:
		assert property (!rd |=> $stable(rdata))
		else $error("read byte changed without a read");
	a_ctrl_indirect:
		assert property ((wr || rd) && indirect |-> addr == CTRL_LOC)
		else $error("indirect access away from control");
	a_high_bits:
		assert property (wr && !indirect && addr == ADDR_HIGH_LOC
			|-> wdata[7:3] == 5'h00)
		else $error("high address upper bits not zero");
endmodule

// file: bench/tb_data_eeprom_access_control.sv
// self-checking bench: driver and controller joined over the link
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin mismatches++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module tb_data_eeprom_access_control;
	import rom_pkg::*;
	logic        clk;             // system clock
	logic        rst;             // sync reset
	logic        sub_clk;         // slow sub-clock, clk / 4
	logic [1:0]  sub_div;         // sub-clock divider
	logic        sub_stable;      // sub-clock stable pin
	logic [3:0]  avs_address;     // bus address
	logic        avs_read;        // bus read
	logic        avs_write;       // bus write
	logic [31:0] avs_writedata;   // bus write data
	logic [31:0] avs_readdata;    // bus read data
	logic        avs_waitrequest; // bus stall
	logic        dev_busy;        // controller busy
	logic [31:0] rv;              // last status word
	int          cyc;             // free cycle count
	int          n;               // cycles of the last command
	int          mismatches;
	int          checks;

	rom_link link_i();
	rom_device u_rom_device (.clk(clk), .rst(rst), .sub_clk(sub_clk),
		.busy(dev_busy), .link(link_i));
	rom_host u_rom_host (.clk(clk), .rst(rst), .sub_stable(sub_stable),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.link(link_i));
	rom_asserts u_rom_asserts (.clk(clk), .rst(rst), .addr(link_i.addr),
		.indirect(link_i.indirect), .wr(link_i.wr), .rd(link_i.rd),
		.wdata(link_i.wdata), .rdata(link_i.rdata), .done(link_i.done));

	// system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// fast sub-clock keeps timed cycles short; it runs free like a crystal
	always @(posedge clk) begin
		sub_div <= sub_div + 2'h1;
		if (sub_div[0])
			sub_clk <= ~sub_clk;
		cyc <= cyc + 1;
	end

	task automatic finish_test();
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one bus access, held until waitrequest is seen low at an edge
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int   i;
		logic st;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		st = 1'b1;
		q  = 32'h0;
		// values read here are those that stood at this rising edge
		for (i = 0; i < 20 && st !== 1'b0; i++) begin
			@(posedge clk);
			st = avs_waitrequest;
			q  = avs_readdata;
		end
		if (st !== 1'b0) begin
			mismatches++;
			finish_test();
		end
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		// idle edge so the strobe is never driven twice in one step
		@(posedge clk);
	endtask

	// command word from op, page mode and long timing
	function automatic logic [31:0] cw(input logic [2:0] o, input logic m,
		input logic c);
		cw = 32'h0;
		cw[2:0] = o;
		cw[CMD_MODE_BIT] = m;
		cw[CMD_CTS_BIT] = c;
	endfunction

	// argument, command, then poll status until idle
	task automatic op(input logic [31:0] c, input logic [31:0] arg);
		int          i;
		int          t0;
		logic [31:0] q;
		av(1'b1, ARG_OFS, arg, q);
		av(1'b1, CMD_OFS, c, q);
		t0 = cyc;
		q  = 32'h1;
		for (i = 0; i < 400 && q[0] !== 1'b0; i++)
			av(1'b0, STATUS_OFS, 32'h0, q);
		if (q[0] !== 1'b0) begin
			mismatches++;
			finish_test();
		end
		n  = cyc - t0;
		rv = q;
	endtask

	// byte read of one location
	task automatic rd_byte(input logic [31:0] a, input logic [7:0] e);
		op(cw(OP_SET_ADDR, 1'b0, 1'b0), a);
		op(cw(OP_READ, 1'b0, 1'b0), 32'h0);
		`CHK(rv[15:8], e, "read back")
	endtask

	// duration against the sub-clock count, four clocks a tick
	task automatic timed(input logic [TIMER_W-1:0] t);
		`CHK((n > int'(t) * 4 - 8) && (n < int'(t) * 4 + 80), 1'b1, "time")
	endtask

	initial begin
		rst = 1'b1;
		sub_clk = 1'b0;
		sub_div = 2'h0;
		sub_stable = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		cyc = 0;
		mismatches = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		av(1'b0, STATUS_OFS, 32'h0, rv);
		`CHK(rv, 32'h0, "status after reset")
		av(1'b0, 4'hC, 32'h0, rv);
		`CHK(rv, 32'h0, "unmapped read")
		// byte program, short then long cycle time
		op(cw(OP_SET_ADDR, 1'b0, 1'b0), 32'h723);
		op(cw(OP_LOAD_DATA, 1'b0, 1'b0), 32'hA5);
		op(cw(OP_PROG, 1'b0, 1'b0), 32'h0);
		timed(PROG_TICKS_SHORT);
		`CHK(rv[1], 1'b1, "done flag")
		rd_byte(32'h723, 8'hA5);
		op(cw(OP_SET_ADDR, 1'b0, 1'b0), 32'h724);
		op(cw(OP_LOAD_DATA, 1'b0, 1'b0), 32'h3C);
		op(cw(OP_PROG, 1'b0, 1'b1), 32'h0);
		timed(PROG_TICKS_LONG);
		rd_byte(32'h724, 8'h3C);
		// page program from slot E: third byte lands on F, no wrap
		op(cw(OP_SET_ADDR, 1'b0, 1'b0), 32'h72E);
		for (int k = 1; k < 4; k++)
			op(cw(OP_LOAD_DATA, 1'b1, 1'b0), 32'h11 * k);
		op(cw(OP_PROG, 1'b1, 1'b0), 32'h0);
		rd_byte(32'h72E, 8'h11);
		rd_byte(32'h72F, 8'h33);
		rd_byte(32'h720, 8'h00);
		// page wipe of slots 2 and 3 only, short; then slot E, long cycle time
		op(cw(OP_SET_ADDR, 1'b0, 1'b0), 32'h722);
		op(cw(OP_LOAD_DATA, 1'b1, 1'b0), 32'hFF);
		op(cw(OP_LOAD_DATA, 1'b1, 1'b0), 32'hFF);
		op(cw(OP_WIPE, 1'b1, 1'b0), 32'h0);
		timed(WIPE_TICKS_SHORT);
		rd_byte(32'h723, 8'h00);
		rd_byte(32'h724, 8'h3C);
		op(cw(OP_SET_ADDR, 1'b0, 1'b0), 32'h72E);
		op(cw(OP_LOAD_DATA, 1'b1, 1'b0), 32'hFF);
		op(cw(OP_WIPE, 1'b1, 1'b1), 32'h0);
		timed(WIPE_TICKS_LONG);
		rd_byte(32'h72E, 8'h00);
		// unstable sub-clock: program refused, nothing completes
		sub_stable <= 1'b0;
		repeat (3) @(posedge clk);
		op(cw(OP_PROG, 1'b0, 1'b0), 32'h0);
		`CHK(rv[2:1], 2'b10, "refused")
		sub_stable <= 1'b1;
		`CHK(dev_busy, 1'b0, "controller idle")
		finish_test();
	end
endmodule
